// ---- shared/psc_pkg.sv ----
// Package for the port statistics counters: offsets, limits and carriers
package psc_pkg;

	localparam int NUM_CNT = 32;
	localparam int CNT_W   = 30;
	localparam int LEN_W   = 11;
	localparam int ADDR_W  = 5;

	// Counter word layout
	localparam int OVF_BIT   = 31;
	localparam int VALID_BIT = 30;
	localparam logic [CNT_W-1:0] CNT_RESET = 30'h00000000;

	// Counter offsets
	localparam logic [4:0] OFS_RX_LOW_PRIORITY_OCTETS = 5'h00;
	localparam logic [4:0] OFS_RESERVED_COUNTER_A     = 5'h01;
	localparam logic [4:0] OFS_RX_SHORT_FRAMES        = 5'h02;
	localparam logic [4:0] OFS_RX_RUNT_BAD_FRAMES     = 5'h03;
	localparam logic [4:0] OFS_RX_LONG_GOOD_FRAMES    = 5'h04;
	localparam logic [4:0] OFS_RX_LONG_BAD_FRAMES     = 5'h05;
	localparam logic [4:0] OFS_RX_BAD_SYMBOL_FRAMES   = 5'h06;
	localparam logic [4:0] OFS_RX_CHECKSUM_FAIL       = 5'h07;
	localparam logic [4:0] OFS_RX_MISALIGNED_FRAMES   = 5'h08;
	localparam logic [4:0] OFS_RX_MAC_CONTROL_FRAMES  = 5'h09;
	localparam logic [4:0] OFS_RX_FLOW_PAUSE_FRAMES   = 5'h0A;
	localparam logic [4:0] OFS_RX_GOOD_BCAST_FRAMES   = 5'h0B;
	localparam logic [4:0] OFS_RX_GOOD_MCAST_FRAMES   = 5'h0C;
	localparam logic [4:0] OFS_RX_GOOD_UCAST_FRAMES   = 5'h0D;
	localparam logic [4:0] OFS_RX_SIZE_BIN_MIN        = 5'h0E;
	localparam logic [4:0] OFS_RX_SIZE_BIN_65_127     = 5'h0F;
	localparam logic [4:0] OFS_RX_SIZE_BIN_128_255    = 5'h10;
	localparam logic [4:0] OFS_RX_SIZE_BIN_256_511    = 5'h11;
	localparam logic [4:0] OFS_RX_SIZE_BIN_512_1023   = 5'h12;
	localparam logic [4:0] OFS_RX_SIZE_BIN_LARGEST    = 5'h13;
	localparam logic [4:0] OFS_TX_LOW_PRIORITY_OCTETS = 5'h14;
	localparam logic [4:0] OFS_RESERVED_COUNTER_B     = 5'h15;
	localparam logic [4:0] OFS_TX_LATE_COLLISIONS     = 5'h16;
	localparam logic [4:0] OFS_TX_FLOW_PAUSE_FRAMES   = 5'h17;
	localparam logic [4:0] OFS_TX_GOOD_BCAST_FRAMES   = 5'h18;
	localparam logic [4:0] OFS_TX_GOOD_MCAST_FRAMES   = 5'h19;
	localparam logic [4:0] OFS_TX_GOOD_UCAST_FRAMES   = 5'h1A;
	localparam logic [4:0] OFS_TX_DELAYED_FIRST       = 5'h1B;
	localparam logic [4:0] OFS_TX_ALL_COLLISIONS      = 5'h1C;
	localparam logic [4:0] OFS_TX_COLLISION_FAILURES  = 5'h1D;
	localparam logic [4:0] OFS_TX_ONE_COLLISION       = 5'h1E;
	localparam logic [4:0] OFS_TX_MANY_COLLISION      = 5'h1F;

	// Frame length limits in octets
	localparam logic [10:0] LEN_MIN      = 11'h040;
	localparam logic [10:0] LEN_MAX      = 11'h600;
	localparam logic [10:0] LEN_BIN_127  = 11'h07F;
	localparam logic [10:0] LEN_BIN_255  = 11'h0FF;
	localparam logic [10:0] LEN_BIN_511  = 11'h1FF;
	localparam logic [10:0] LEN_BIN_1023 = 11'h3FF;
	localparam logic [10:0] LEN_LONGEST  = 11'h77C;

	// Control frame identification
	localparam logic [15:0] ETYPE_MAC_CTRL = 16'h8808;
	localparam logic [15:0] OPCODE_PAUSE   = 16'h0001;

	// One finished receive frame, valid for one cycle
	typedef struct packed {
		logic        done;
		logic [10:0] len;
		logic        crc_ok;
		logic        sym_err;
		logic        odd_bits;
		logic        dst_bcast;
		logic        dst_mcast;
		logic        dst_pause;
		logic [15:0] etype;
		logic [15:0] opcode;
	} psc_rx_ev_t;

	// One finished transmit attempt, valid for one cycle
	typedef struct packed {
		logic        done;
		logic [10:0] len;
		logic        ok;
		logic        dst_bcast;
		logic        dst_mcast;
		logic        pause;
		logic        deferred;
		logic        excess;
		logic [4:0]  ncoll;
	} psc_tx_ev_t;

	// Collision pulses from the transmitter
	typedef struct packed {
		logic coll;
		logic late;
		logic full_duplex;
	} psc_coll_ev_t;

	// Indirect read request
	typedef struct packed {
		logic       req;
		logic [4:0] addr;
	} psc_rd_req_t;

	typedef logic [NUM_CNT-1:0][LEN_W-1:0] psc_inc_t;

	// Whole block state
	typedef struct packed {
		logic [NUM_CNT-1:0]          ovf;
		logic [NUM_CNT-1:0][CNT_W-1:0] cnt;
		logic [31:0]                 rd_data;
		logic                        rd_valid;
	} psc_state_t;

endpackage

// ---- verilog/psc_counters.sv ----
// Port statistics counters with read-clear indirect access
`timescale 1ns/1ps

// How it works
// - Thirty per-port activity counters are kept, plus two reserved slots.
// - Bit 31 reports counter overflow.
// - Bit 30 reports count valid.
// - Bits 29-0 count, reset zero, read clears.
// - Counters reached only by indirect offsets 0x00-0x1F.
// - 0x0 adds received default octets, bad included.
// - 0x2 counts short frames with good CRC.
// - 0x3 counts short frames with errors.
// - 0x4 counts frames above 1536 bytes with good CRC.
// - 0x5 counts bad frames above 1536 bytes.
// - 0x6 counts legal-length frames with symbol error.
// - 0x7 counts whole-byte 64-1916 frames, bad CRC.
// - 0x8 counts odd-bit 64-1916 frames, bad CRC.
// - 0x9 counts received control frames, type 8808.
// - 0xA counts fully qualified received pause frames.
// - 0xB-0xD count good broadcast, non-control multicast, unicast.
// - 0xE-0x13 bin received frames of 64-1916 octets by length.
// - 0x14 adds good transmitted octets, pause included.
// - 0x16 counts collisions after 512 bit-times.
// - 0x17 counts transmitted pause frames.
// - 0x18 counts good transmitted broadcast frames.
// - 0x19-0x1F count other transmit outcomes.
module psc_counters (
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst,
	// Frame events from the MAC
	input  wire psc_pkg::psc_rx_ev_t   rx_ev,
	input  wire psc_pkg::psc_tx_ev_t   tx_ev,
	input  wire psc_pkg::psc_coll_ev_t coll_ev,
	// Indirect counter read
	input  wire psc_pkg::psc_rd_req_t  rd_req,
	output logic [31:0]                rd_data,
	output logic                       rd_valid
);

	psc_pkg::psc_state_t st_r;
	psc_pkg::psc_state_t st_nxt;
	psc_pkg::psc_inc_t   inc;

	function automatic logic in_range(
		input logic [10:0] len,
		input logic [10:0] lo,
		input logic [10:0] hi
	);
		in_range = (len >= lo) && (len <= hi);
	endfunction

	function automatic logic [10:0] flag_inc(input logic f);
		flag_inc = {10'h000, f};
	endfunction

	function automatic psc_pkg::psc_inc_t classify(
		input psc_pkg::psc_rx_ev_t   rx,
		input psc_pkg::psc_tx_ev_t   tx,
		input psc_pkg::psc_coll_ev_t ce
	);
		logic        rxd;
		logic        rx_short;
		logic        rx_long;
		logic        rx_err;
		logic        rx_legal;
		logic        rx_ctrl;
		logic        rx_good;
		logic        rx_bc;
		logic        rx_mc;
		logic        txg;
		psc_pkg::psc_inc_t v;
		v        = '0;
		rxd      = rx.done;
		rx_short = rx.len < psc_pkg::LEN_MIN;
		rx_long  = rx.len > psc_pkg::LEN_MAX;
		rx_err   = !rx.crc_ok || rx.sym_err || rx.odd_bits;
		rx_legal = in_range(rx.len, psc_pkg::LEN_MIN, psc_pkg::LEN_MAX);
		rx_ctrl  = rx.etype == psc_pkg::ETYPE_MAC_CTRL;
		rx_good  = rx_legal && !rx_err;
		rx_bc    = rx_good && rx.dst_bcast;
		rx_mc    = rx_good && rx.dst_mcast && !rx.dst_bcast;
		txg      = tx.done && tx.ok;

		// Receive octets, bad frames too
		if (rxd) begin
			v[psc_pkg::OFS_RX_LOW_PRIORITY_OCTETS] = rx.len;
		end
		v[psc_pkg::OFS_RX_SHORT_FRAMES] =
			flag_inc(rxd && rx_short && rx.crc_ok);
		v[psc_pkg::OFS_RX_RUNT_BAD_FRAMES] =
			flag_inc(rxd && rx_short && rx_err);
		v[psc_pkg::OFS_RX_LONG_GOOD_FRAMES] =
			flag_inc(rxd && rx_long && rx.crc_ok);
		v[psc_pkg::OFS_RX_LONG_BAD_FRAMES] =
			flag_inc(rxd && rx_long && rx_err);
		v[psc_pkg::OFS_RX_BAD_SYMBOL_FRAMES] =
			flag_inc(rxd && rx_legal && rx.sym_err);
		v[psc_pkg::OFS_RX_CHECKSUM_FAIL] =
			flag_inc(rxd && !rx.crc_ok && !rx.odd_bits &&
				in_range(rx.len, psc_pkg::LEN_MIN,
					psc_pkg::LEN_LONGEST));
		v[psc_pkg::OFS_RX_MISALIGNED_FRAMES] =
			flag_inc(rxd && !rx.crc_ok && rx.odd_bits &&
				in_range(rx.len, psc_pkg::LEN_MIN,
					psc_pkg::LEN_LONGEST));
		v[psc_pkg::OFS_RX_MAC_CONTROL_FRAMES] =
			flag_inc(rxd && rx_ctrl);
		v[psc_pkg::OFS_RX_FLOW_PAUSE_FRAMES] =
			flag_inc(rxd && rx_ctrl && rx.dst_pause && rx.crc_ok &&
				rx.opcode == psc_pkg::OPCODE_PAUSE &&
				!rx_short);

		// Destination classes, good frames only
		v[psc_pkg::OFS_RX_GOOD_BCAST_FRAMES] =
			flag_inc(rxd && rx_bc);
		v[psc_pkg::OFS_RX_GOOD_MCAST_FRAMES] =
			flag_inc(rxd && rx_mc && !rx_ctrl);
		v[psc_pkg::OFS_RX_GOOD_UCAST_FRAMES] =
			flag_inc(rxd && rx_good && !rx.dst_bcast &&
				!rx.dst_mcast);

		// Length bins, bad frames included
		v[psc_pkg::OFS_RX_SIZE_BIN_MIN] =
			flag_inc(rxd && rx.len == psc_pkg::LEN_MIN);
		v[psc_pkg::OFS_RX_SIZE_BIN_65_127] =
			flag_inc(rxd && in_range(rx.len, psc_pkg::LEN_MIN + 11'h001,
				psc_pkg::LEN_BIN_127));
		v[psc_pkg::OFS_RX_SIZE_BIN_128_255] =
			flag_inc(rxd && in_range(rx.len,
				psc_pkg::LEN_BIN_127 + 11'h001,
				psc_pkg::LEN_BIN_255));
		v[psc_pkg::OFS_RX_SIZE_BIN_256_511] =
			flag_inc(rxd && in_range(rx.len,
				psc_pkg::LEN_BIN_255 + 11'h001,
				psc_pkg::LEN_BIN_511));
		v[psc_pkg::OFS_RX_SIZE_BIN_512_1023] =
			flag_inc(rxd && in_range(rx.len,
				psc_pkg::LEN_BIN_511 + 11'h001,
				psc_pkg::LEN_BIN_1023));
		v[psc_pkg::OFS_RX_SIZE_BIN_LARGEST] =
			flag_inc(rxd && in_range(rx.len,
				psc_pkg::LEN_BIN_1023 + 11'h001,
				psc_pkg::LEN_LONGEST));

		// Transmit side
		if (txg) begin
			v[psc_pkg::OFS_TX_LOW_PRIORITY_OCTETS] = tx.len;
		end
		v[psc_pkg::OFS_TX_LATE_COLLISIONS] =
			flag_inc(ce.late);
		v[psc_pkg::OFS_TX_FLOW_PAUSE_FRAMES] =
			flag_inc(txg && tx.pause);
		v[psc_pkg::OFS_TX_GOOD_BCAST_FRAMES] =
			flag_inc(txg && tx.dst_bcast);
		v[psc_pkg::OFS_TX_GOOD_MCAST_FRAMES] =
			flag_inc(txg && tx.dst_mcast && !tx.dst_bcast);
		v[psc_pkg::OFS_TX_GOOD_UCAST_FRAMES] =
			flag_inc(txg && !tx.dst_mcast && !tx.dst_bcast);
		v[psc_pkg::OFS_TX_DELAYED_FIRST] =
			flag_inc(tx.done && tx.deferred);
		v[psc_pkg::OFS_TX_ALL_COLLISIONS] =
			flag_inc(ce.coll && !ce.full_duplex);
		v[psc_pkg::OFS_TX_COLLISION_FAILURES] =
			flag_inc(tx.done && tx.excess);
		v[psc_pkg::OFS_TX_ONE_COLLISION] =
			flag_inc(txg && tx.ncoll == 5'h01);
		v[psc_pkg::OFS_TX_MANY_COLLISION] =
			flag_inc(txg && tx.ncoll > 5'h01);

		// Reserved slots never count
		v[psc_pkg::OFS_RESERVED_COUNTER_A] = '0;
		v[psc_pkg::OFS_RESERVED_COUNTER_B] = '0;
		classify = v;
	endfunction

	function automatic logic is_reserved(input logic [4:0] a);
		is_reserved = (a == psc_pkg::OFS_RESERVED_COUNTER_A) ||
			(a == psc_pkg::OFS_RESERVED_COUNTER_B);
	endfunction

	assign inc = classify(rx_ev, tx_ev, coll_ev);

	always_comb begin
		logic [30:0] sum;
		logic        hit;
		sum    = '0;
		hit    = 1'b0;
		st_nxt = st_r;
		st_nxt.rd_valid = rd_req.req;
		if (rd_req.req) begin
			// Snapshot before clearing; reserved slots read as zero
			if (is_reserved(rd_req.addr)) begin
				st_nxt.rd_data = 32'h00000000;
			end else begin
				st_nxt.rd_data = {st_r.ovf[rd_req.addr],
					1'b1,
					st_r.cnt[rd_req.addr]};
			end
		end
		for (int i = 0; i < psc_pkg::NUM_CNT; i++) begin
			hit = rd_req.req && (rd_req.addr == 5'(i));
			if (hit) begin
				// Read clears, an event in the same cycle is kept
				st_nxt.cnt[i] = 30'(inc[i]);
				st_nxt.ovf[i] = 1'b0;
			end else begin
				sum = {1'b0, st_r.cnt[i]} + 31'(inc[i]);
				st_nxt.cnt[i] = sum[29:0];
				st_nxt.ovf[i] = st_r.ovf[i] | sum[30];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_r.ovf      <= '0;
			st_r.cnt      <= {psc_pkg::NUM_CNT{psc_pkg::CNT_RESET}};
			st_r.rd_data  <= 32'h00000000;
			st_r.rd_valid <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rd_data  = st_r.rd_data;
	assign rd_valid = st_r.rd_valid;

endmodule

// ---- tb/psc_host_model.sv ----
// Host model issuing indirect counter reads
`timescale 1ns/1ps
module psc_host_model (
	// Clock and reset
	input  wire logic            clk,
	input  wire logic            rst,
	// Read commands
	input  wire logic            go,
	input  wire logic [4:0]      addr,
	// Counter read port
	output psc_pkg::psc_rd_req_t rd_req,
	input  wire logic [31:0]     rd_data,
	input  wire logic            rd_valid
);
	logic       rt_r;
	logic       rt_d_r;
	logic [4:0] last_r;
	always @(posedge clk) begin
		rt_d_r <= rt_r;
		last_r <= rd_req.addr;
		rt_r <= 1'b0;
		if (rst)
			rd_req <= '0;
		else if (rd_valid && !rd_data[30] && !rt_d_r) begin
			rd_req <= {1'b1, last_r};
			rt_r <= 1'b1;
		end else
			rd_req <= {go, addr};
	end
endmodule

// ---- tb/psc_counters_monitor.sv ----
// Checker bound to the statistics counters
`timescale 1ns/1ps
module psc_counters_monitor (
	// Clock and reset
	input wire logic                 clk,
	input wire logic                 rst,
	// Watched ports
	input wire psc_pkg::psc_rx_ev_t  rx_ev,
	input wire psc_pkg::psc_rd_req_t rd_req,
	input wire logic [31:0]          rd_data,
	input wire logic                 rd_valid
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic rsv;
	assign rsv = rd_req.addr == 5'h01 || rd_req.addr == 5'h15;
	a_answer_next: assert property (rd_req.req |=> rd_valid)
		else $error("read not answered");
	a_no_stray: assert property (!rd_req.req |=> !rd_valid)
		else $error("answer without read");
	a_reset_zero: assert property ($fell(rst) |-> !rd_valid &&
		rd_data == 32'h00000000) else $error("not quiet after reset");
	a_rsvd_word: assert property (rd_req.req && rsv |=>
		rd_data == 32'h00000000) else $error("reserved word not zero");
	a_valid_flag: assert property (rd_req.req && !rsv |=>
		rd_data[30]) else $error("valid flag low");
	a_read_clear: assert property ((rd_req.req && !rx_ev.done &&
		rd_req.addr == 5'h0E) [*2] |=> rd_data[29:0] == 30'h00000000)
		else $error("count not cleared by read");
	a_data_hold: assert property (!rd_req.req |=> $stable(rd_data))
		else $error("read word changed");
	a_bin_min: assert property (rx_ev.done && rx_ev.len == 11'h040
		##1 rd_req.req && rd_req.addr == 5'h0E |=> rd_data[29:0] != 0)
		else $error("minimum size frame not binned");
endmodule
bind psc_counters psc_counters_monitor i_mon (.clk, .rst, .rx_ev,
	.rd_req, .rd_data, .rd_valid);

// ---- tb/psc_counters_tb.sv ----
// Self-checking bench for the statistics counters
`timescale 1ns/1ps
module psc_counters_tb;
	logic                  clk;
	logic                  rst;
	logic                  go;
	logic [4:0]            addr;
	psc_pkg::psc_rx_ev_t   rx_ev;
	psc_pkg::psc_tx_ev_t   tx_ev;
	psc_pkg::psc_coll_ev_t coll_ev;
	psc_pkg::psc_rd_req_t  rd_req;
	logic [31:0]           rd_data;
	logic                  rd_valid;
	logic [31:0]           r;
	logic [10:0]           lens [16];
	longint                cnt [32];
	bit [31:0]             ovf;
	logic [31:0]           exp_q [$];
	logic [4:0]            ra;
	logic                  ct;
	logic                  g;
	logic                  rx_bad;
	int                    ln;
	int                    fail_count;
	int                    tests_run;
	int                    cyc;

	psc_counters i_dut (.clk, .rst, .rx_ev, .tx_ev, .coll_ev, .rd_req,
		.rd_data, .rd_valid);
	psc_host_model i_host (.clk, .rst, .go, .addr, .rd_req, .rd_data,
		.rd_valid);

	always #20 clk = ~clk;

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t word %h expected %h", $time, got, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic add(input int i, input int v);
		longint c;
		c = cnt[i] + v;
		if (c >= 64'h40000000) begin
			ovf[i] = 1'b1;
			c -= 64'h40000000;
		end
		cnt[i] = c;
	endtask

	// Reference model fed from the sampled block inputs
	always @(posedge clk) begin
		if (rst) begin
			foreach (cnt[i]) cnt[i] = 0;
			ovf = '0;
			exp_q.delete();
		end else begin
			if (rd_valid) chk(rd_data, exp_q.pop_front());
			if (rd_req.req) begin
				ra = rd_req.addr;
				exp_q.push_back((ra == 5'h01 || ra == 5'h15) ? 32'h00000000 :
					{ovf[ra], 1'b1, cnt[ra][29:0]});
				cnt[ra] = 0;
				ovf[ra] = 1'b0;
			end
			if (rx_ev.done) begin
				ln = rx_ev.len;
				ct = rx_ev.etype == 16'h8808;
				rx_bad = !rx_ev.crc_ok || rx_ev.sym_err || rx_ev.odd_bits;
				g = ln >= 64 && ln <= 1536 && !rx_bad;
				add(0, ln);
				if (ln < 64 && rx_ev.crc_ok) add(2, 1);
				if (ln < 64 && rx_bad) add(3, 1);
				if (ln > 1536 && rx_ev.crc_ok) add(4, 1);
				if (ln > 1536 && rx_bad) add(5, 1);
				if (ln >= 64 && ln <= 1536 && rx_ev.sym_err)
					add(6, 1);
				if (ln >= 64 && ln <= 1916 && !rx_ev.crc_ok)
					add(rx_ev.odd_bits ? 8 : 7, 1);
				if (ct) add(9, 1);
				if (ct && rx_ev.dst_pause && rx_ev.opcode == 16'h0001 && ln >= 64 &&
					rx_ev.crc_ok) add(10, 1);
				if (g && rx_ev.dst_bcast) add(11, 1);
				if (g && !rx_ev.dst_bcast && rx_ev.dst_mcast && !ct) add(12, 1);
				if (g && !rx_ev.dst_bcast && !rx_ev.dst_mcast) add(13, 1);
				if (ln >= 64) add(ln == 64 ? 14 : ln < 128 ? 15 : ln < 256 ? 16 :
					ln < 512 ? 17 : ln < 1024 ? 18 : 19, 1);
			end
			if (tx_ev.done) begin
				if (tx_ev.ok) add(20, tx_ev.len);
				if (tx_ev.ok && tx_ev.pause) add(23, 1);
				if (tx_ev.ok && tx_ev.dst_bcast) add(24, 1);
				if (tx_ev.ok && !tx_ev.dst_bcast)
					add(tx_ev.dst_mcast ? 25 : 26, 1);
				if (tx_ev.deferred) add(27, 1);
				if (tx_ev.excess) add(29, 1);
				if (tx_ev.ok && tx_ev.ncoll != 0)
					add(tx_ev.ncoll == 1 ? 30 : 31, 1);
			end
			if (coll_ev.late) add(22, 1);
			if (coll_ev.coll && !coll_ev.full_duplex) add(28, 1);
		end
	end

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fail_count++;
			report_and_stop();
		end
	end

	task automatic step();
		logic [10:0] l;
		@(posedge clk);
		r = lfsr(r);
		l = lens[r[4:1]];
		rx_ev <= {r[0], l, r[5], r[6] && r[30],
			!r[5] && r[7], r[10:8], r[11] ? 16'h8808 : 16'h0800,
			r[12] ? 16'h0001 : 16'h0002};
		tx_ev <= {r[13], lens[r[17:14]], r[18], r[20:19], r[21], r[22],
			!r[18] && r[23], 3'h0, r[25:24]};
		coll_ev <= {r[26], r[26] && r[27], r[28]};
		go <= r[31] && r[2];
		addr <= r[31:27];
	endtask

	task automatic rd(input logic [4:0] a, input psc_pkg::psc_rx_ev_t e);
		@(posedge clk);
		rx_ev <= e;
		tx_ev <= '0;
		coll_ev <= '0;
		go <= 1'b1;
		addr <= a;
	endtask

	task automatic sweep();
		rd(5'h0E, {1'b1, 11'h040, 1'b1, 5'h00, 16'h0800, 16'h0000});
		for (int a = 0; a < 32; a++) rd(a[4:0], '0);
		rd(5'h0E, '0);
		rd(5'h0E, '0);
		@(posedge clk);
		go <= 1'b0;
		repeat (6) @(posedge clk);
	endtask

	initial begin
		clk = 1'b0;
		rst = 1'b1;
		go = 1'b0;
		addr = 5'h00;
		rx_ev = '0;
		tx_ev = '0;
		coll_ev = '0;
		r = 32'h000081E3;
		cyc = 0;
		fail_count = 0;
		tests_run = 0;
		lens = '{11'h03F, 11'h040, 11'h041, 11'h07F, 11'h080, 11'h0FF,
			11'h100, 11'h1FF, 11'h200, 11'h3FF, 11'h400, 11'h600,
			11'h601, 11'h77C, 11'h028, 11'h2BC};
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		sweep();
		$display("test reset_sweep done");
		repeat (300) step();
		// Reset in mid-run, traffic left standing on the inputs
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		$display("test mid_reset done");
		repeat (300) step();
		sweep();
		sweep();
		$display("test random_traffic done");
		report_and_stop();
	end
endmodule
